// *** common/buck_seq_map.svh ***
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef BUCK_SEQ_MAP_SVH
`define BUCK_SEQ_MAP_SVH
// register byte addresses
`define REG_CTRL 5'h00
`define REG_FAULT_CFG 5'h04
`define REG_INPUT_UNDERVOLTAGE_LOCKOUT 5'h08
`define REG_TIMING 5'h0C
`define REG_STATUS 5'h10
`define REG_COMP 5'h14
`define REG_TARGET 5'h18
`define REG_DUTY 5'h1C
// ctrl fields
`define CTRL_ENABLE 0
`define CTRL_DIODE_EMU 1
`define CTRL_SINGLE_PHASE 2
`define CTRL_EXT_CLOCK 3
`define CTRL_RESTART 4
`define CTRL_RESET 32'h0000_0004
// fault config: [1:0] input_undervoltage_lockout response, [2] ov response, [6:4] retry count
`define FCFG_RESET 32'h0000_0002
// input_undervoltage_lockout threshold in 10 mV steps
`define INPUT_UNDERVOLTAGE_LOCKOUT_MIN 12'd285
`define INPUT_UNDERVOLTAGE_LOCKOUT_MAX 12'd1600
`define INPUT_UNDERVOLTAGE_LOCKOUT_STRAP_MIN 12'd450
`define INPUT_UNDERVOLTAGE_LOCKOUT_STRAP_MAX 12'd1080
`define INPUT_UNDERVOLTAGE_LOCKOUT_RESET 12'd450
// timing: [7:0] turn-on delay, [15:8] tristate delay, [23:16] tristate off delay, [31:24] step
`define TIMING_RESET 32'h0404_0404
`define TARGET_RESET 12'h800
// overvoltage at target + 15 %: threshold = target + target*15/100
`define OV_PCT 15
`define OV_DIV 100
// fault continue delay in us, and cycles at 25 MHz
`define UV_DELAY_US 10
`define CLK_MHZ 25
`define UV_DELAY_CYC (`UV_DELAY_US * `CLK_MHZ)
`define DEAD_MIN 4'h1
`define DEAD_MAX 4'hF
`define DEAD_RESET 4'h4
`endif

// *** common/buck_seq_pkg.sv ***
// types shared by the sequencer
package buck_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_TRI = 3'b001,
    ST_RAMP = 3'b011,
    ST_RUN = 3'b010,
    ST_FALL = 3'b110,
    ST_TRI_OFF = 3'b111,
    ST_FAULT = 3'b101
  } seq_state_t;
  typedef enum logic [1:0] {
    UV_CONTINUE = 2'b00,
    UV_DELAY_STOP = 2'b01,
    UV_SHUTDOWN = 2'b10
  } uv_resp_t;
  typedef enum logic {
    OV_SHUTDOWN = 1'b0,
    OV_CROWBAR = 1'b1
  } ov_resp_t;
endpackage

// *** rtl/buck_fault_and_prebias_sequencer.sv ***
// fault response, pre-bias sequencing and gate policy of a digital buck controller
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "buck_seq_map.svh"

module buck_fault_and_prebias_sequencer
  import buck_seq_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // sensed levels from converters, 10 mV steps
  input wire logic [11:0] input_voltage_in,
  input wire logic [11:0] output_sense_input_in,
  // straps: undervoltage code and compensation resistor code
  input wire logic [2:0] input_undervoltage_lockout_strap_in,
  input wire logic [4:0] compensation_strap_pin_in,
  // light-load indication and duty demand from the loop
  input wire logic light_load_in,
  input wire logic [11:0] loop_duty_in,
  // pins toward the driver
  output logic high_side_pwm_out,
  output logic high_side_pwm_oe_out,
  output logic low_side_gate_out,
  output logic driver_control_out,
  output logic power_good_out,
  // compensation preset and duty
  output logic nonlinear_response_loop_out,
  output logic [3:0] comp_preset_out,
  output logic [11:0] duty_out
);
  import buck_seq_pkg::*;

  logic [31:0] ctrl_ff, fcfg_ff, timing_ff;
  logic [11:0] input_undervoltage_lockout_ff, target_ff, duty_ff, ref_ff;
  logic strap_done_ff, rdy_ff;
  seq_state_t state_ff;
  logic [7:0] tmr_ff;
  logic [2:0] retry_ff;
  logic [15:0] uv_cnt_ff;
  logic latched_ff, crowbar_ff;
  logic [7:0] pwm_cnt_ff;
  logic [3:0] dead_ff;
  logic [11:0] prev_duty_ff;
  logic [4:0] comp_ff;
  logic pg_ff;

  logic enable, ext_clk, uv_fault, ov_fault, stop_now, diode_emu;
  uv_resp_t uv_resp;
  ov_resp_t ov_resp;
  logic [12:0] ov_thresh;
  logic [11:0] wr_input_undervoltage_lockout;
  logic [11:0] strap_input_undervoltage_lockout;
  logic [7:0] step;

  assign enable = ctrl_ff[`CTRL_ENABLE];
  assign ext_clk = ctrl_ff[`CTRL_EXT_CLOCK];
  assign diode_emu = ctrl_ff[`CTRL_DIODE_EMU] & ctrl_ff[`CTRL_SINGLE_PHASE];
  assign uv_resp = uv_resp_t'(fcfg_ff[1:0]);
  assign ov_resp = ext_clk ? OV_SHUTDOWN : ov_resp_t'(fcfg_ff[2]);
  assign step = timing_ff[31:24];
  assign uv_fault = input_voltage_in < input_undervoltage_lockout_ff;
  // target + 15 %, computed at 13 bits so no overflow at full scale
  assign ov_thresh = 13'(target_ff) + 13'((20'(target_ff) * 20'd`OV_PCT) / 20'd`OV_DIV);
  assign ov_fault = 13'(output_sense_input_in) > ov_thresh;
  // strap codes evenly spaced over the strap range, 900 mV per code
  assign strap_input_undervoltage_lockout = `INPUT_UNDERVOLTAGE_LOCKOUT_STRAP_MIN + 12'(input_undervoltage_lockout_strap_in) * 12'd90;
  assign wr_input_undervoltage_lockout = avs_writedata_in[11:0] < `INPUT_UNDERVOLTAGE_LOCKOUT_MIN ? `INPUT_UNDERVOLTAGE_LOCKOUT_MIN :
                   avs_writedata_in[11:0] > `INPUT_UNDERVOLTAGE_LOCKOUT_MAX ? `INPUT_UNDERVOLTAGE_LOCKOUT_MAX : avs_writedata_in[11:0];

  // shutdown causes; undervoltage continue never stops the output
  always_comb begin
    stop_now = 1'b0;
    if (ov_fault && ov_resp == OV_SHUTDOWN) begin
      stop_now = 1'b1;
    end
    if (uv_fault && uv_resp == UV_SHUTDOWN) begin
      stop_now = 1'b1;
    end
    if (uv_resp == UV_DELAY_STOP && uv_fault && uv_cnt_ff >= 16'(`UV_DELAY_CYC)) begin
      stop_now = 1'b1;
    end
  end

  // bus: one wait state, then answer
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~rdy_ff;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_ff <= 1'b0;
    end else begin
      rdy_ff <= (avs_read_in | avs_write_in) & ~rdy_ff;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `CTRL_RESET;
      fcfg_ff <= `FCFG_RESET;
      timing_ff <= `TIMING_RESET;
      target_ff <= `TARGET_RESET;
    end else begin
      if (avs_write_in && rdy_ff) begin
        unique case (avs_address_in)
          `REG_CTRL: ctrl_ff <= {27'h0, avs_writedata_in[4:0]};
          `REG_FAULT_CFG: fcfg_ff <= {25'h0, avs_writedata_in[6:4], 1'b0, avs_writedata_in[2:0]};
          `REG_TIMING: timing_ff <= avs_writedata_in;
          `REG_TARGET: target_ff <= avs_writedata_in[11:0];
          default: ;
        endcase
      end
      // restart is a self-clearing command
      if (ctrl_ff[`CTRL_RESTART] && !(avs_write_in && rdy_ff && avs_address_in == `REG_CTRL)) begin
        ctrl_ff[`CTRL_RESTART] <= 1'b0;
      end
    end
  end

  // threshold: strap caught once after reset, software write overrides
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      input_undervoltage_lockout_ff <= `INPUT_UNDERVOLTAGE_LOCKOUT_RESET;
      strap_done_ff <= 1'b0;
    end else if (avs_write_in && rdy_ff && avs_address_in == `REG_INPUT_UNDERVOLTAGE_LOCKOUT) begin
      input_undervoltage_lockout_ff <= wr_input_undervoltage_lockout;
      strap_done_ff <= 1'b1;
    end else if (!strap_done_ff) begin
      input_undervoltage_lockout_ff <= strap_input_undervoltage_lockout > `INPUT_UNDERVOLTAGE_LOCKOUT_STRAP_MAX ? `INPUT_UNDERVOLTAGE_LOCKOUT_STRAP_MAX : strap_input_undervoltage_lockout;
      strap_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      comp_ff <= 5'h00;
    end else if (!strap_done_ff) begin
      comp_ff <= compensation_strap_pin_in;
    end
  end
  // codes 0..8 are 10k..21.5k (loop off), 9..17 are 23.7k..51.1k (loop on)
  assign nonlinear_response_loop_out = comp_ff >= 5'd9;
  assign comp_preset_out = comp_ff >= 5'd9 ? 4'(comp_ff - 5'd9) : comp_ff[3:0];

  // continue-then-stop delay counter
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      uv_cnt_ff <= 16'h0000;
    end else if (!uv_fault) begin
      uv_cnt_ff <= 16'h0000;
    end else if (uv_cnt_ff < 16'(`UV_DELAY_CYC)) begin
      uv_cnt_ff <= uv_cnt_ff + 16'h0001;
    end
  end

  // sequencer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_OFF;
      tmr_ff <= 8'h00;
      duty_ff <= 12'h000;
      ref_ff <= 12'h000;
      retry_ff <= 3'h0;
      latched_ff <= 1'b0;
      crowbar_ff <= 1'b0;
    end else begin
      tmr_ff <= tmr_ff + 8'h01;
      if (ctrl_ff[`CTRL_RESTART]) begin
        latched_ff <= 1'b0;
        retry_ff <= fcfg_ff[6:4];
      end
      if (ov_fault && ov_resp == OV_CROWBAR && state_ff != ST_OFF) begin
        crowbar_ff <= 1'b1;
        state_ff <= ST_FAULT;
      end else begin
        unique case (state_ff)
          ST_OFF: begin
            crowbar_ff <= 1'b0;
            if (enable && !latched_ff && !stop_now) begin
              state_ff <= ST_TRI;
              tmr_ff <= 8'h00;
              retry_ff <= fcfg_ff[6:4];
            end
          end
          ST_TRI: begin
            // sample the pre-bias ratio during the turn-on delay
            duty_ff <= output_sense_input_in;
            ref_ff <= output_sense_input_in;
            if (stop_now || !enable) begin
              state_ff <= ST_TRI_OFF;
              tmr_ff <= 8'h00;
            end else if (tmr_ff >= timing_ff[7:0]) begin
              state_ff <= ST_RAMP;
            end
          end
          ST_RAMP, ST_RUN: begin
            if (stop_now) begin
              state_ff <= ST_FAULT;
            end else if (!enable) begin
              state_ff <= ST_FALL;
              tmr_ff <= 8'h00;
            end else if (state_ff == ST_RAMP) begin
              if (target_ff - ref_ff <= 12'(step)) begin
                ref_ff <= target_ff;
                state_ff <= ST_RUN;
              end else begin
                ref_ff <= ref_ff + 12'(step);
              end
              duty_ff <= ref_ff;
            end else begin
              duty_ff <= loop_duty_in;
            end
          end
          ST_FALL: begin
            if (stop_now) begin
              state_ff <= ST_FAULT;
            end else if (ref_ff != 12'h000 && ref_ff <= 12'(step)) begin
              ref_ff <= 12'h000;
              duty_ff <= 12'h000;
              tmr_ff <= 8'h00;
            end else if (ref_ff == 12'h000) begin
              // hold at zero for the tristate delay before letting go
              if (tmr_ff >= timing_ff[15:8]) begin
                state_ff <= ST_TRI_OFF;
                tmr_ff <= 8'h00;
              end
            end else begin
              ref_ff <= ref_ff - 12'(step);
              duty_ff <= ref_ff;
            end
          end
          ST_TRI_OFF: begin
            if (tmr_ff >= timing_ff[23:16]) begin
              state_ff <= ST_OFF;
            end
          end
          ST_FAULT: begin
            duty_ff <= 12'h000;
            if (crowbar_ff) begin
              // low side stays on until software asks for a restart
              if (ctrl_ff[`CTRL_RESTART]) begin
                crowbar_ff <= 1'b0;
                state_ff <= ST_OFF;
              end
            end else if (uv_resp == UV_DELAY_STOP && uv_fault &&
                         uv_cnt_ff >= 16'(`UV_DELAY_CYC)) begin
              latched_ff <= 1'b1;
              state_ff <= ST_OFF;
            end else if (!stop_now && !(ov_fault && ov_resp == OV_CROWBAR)) begin
              if (fcfg_ff[6:4] == 3'h0) begin
                state_ff <= ST_OFF;
              end else if (retry_ff != 3'h0) begin
                retry_ff <= retry_ff - 3'h1;
                state_ff <= ST_OFF;
              end else begin
                latched_ff <= 1'b1;
                state_ff <= ST_OFF;
              end
            end
          end
          default: state_ff <= ST_OFF;
        endcase
      end
    end
  end

  // pwm carrier, 256 steps; duty uses the upper 8 bits
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_cnt_ff <= 8'h00;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
    end
  end

  // adaptive dead time: shrink while duty falls or holds, back off when it rises
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dead_ff <= `DEAD_RESET;
      prev_duty_ff <= 12'h000;
    end else if (state_ff == ST_RUN && pwm_cnt_ff == 8'hFF) begin
      prev_duty_ff <= loop_duty_in;
      if (loop_duty_in > prev_duty_ff && dead_ff < `DEAD_MAX) begin
        dead_ff <= dead_ff + 4'h1;
      end else if (loop_duty_in <= prev_duty_ff && dead_ff > `DEAD_MIN) begin
        dead_ff <= dead_ff - 4'h1;
      end
    end
  end

  logic active, hs_on, ls_on;
  assign active = state_ff == ST_RAMP || state_ff == ST_RUN || state_ff == ST_FALL;
  always_comb begin
    hs_on = active && pwm_cnt_ff < duty_ff[11:4];
    // low side waits dead time after high side ends and stops dead time before
    ls_on = active && pwm_cnt_ff >= 8'(duty_ff[11:4] + 8'(dead_ff)) &&
            pwm_cnt_ff < 8'(8'hFF - 8'(dead_ff)) && !(diode_emu && light_load_in);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      high_side_pwm_out <= 1'b0;
      high_side_pwm_oe_out <= 1'b1;
      low_side_gate_out <= 1'b0;
      driver_control_out <= 1'b0;
      pg_ff <= 1'b0;
    end else begin
      driver_control_out <= state_ff != ST_OFF;
      if (crowbar_ff || state_ff == ST_FAULT && ov_fault && ov_resp == OV_CROWBAR) begin
        high_side_pwm_out <= 1'b0;
        high_side_pwm_oe_out <= 1'b1;
        low_side_gate_out <= 1'b1;
      end else begin
        high_side_pwm_out <= hs_on && !ls_on;
        low_side_gate_out <= ls_on && !hs_on;
        // tri-state while waiting either side of the active ramp
        high_side_pwm_oe_out <= !(state_ff == ST_TRI || state_ff == ST_TRI_OFF);
      end
      pg_ff <= state_ff == ST_RUN && !ov_fault;
    end
  end
  assign power_good_out = pg_ff && !ov_fault;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !rdy_ff) begin
      unique case (avs_address_in)
        `REG_CTRL: avs_readdata_out <= ctrl_ff;
        `REG_FAULT_CFG: avs_readdata_out <= fcfg_ff;
        `REG_INPUT_UNDERVOLTAGE_LOCKOUT: avs_readdata_out <= {20'h0, input_undervoltage_lockout_ff};
        `REG_TIMING: avs_readdata_out <= timing_ff;
        `REG_STATUS: avs_readdata_out <= {16'h0, 1'b0, retry_ff, dead_ff, latched_ff,
                                           crowbar_ff, ov_fault, uv_fault, 1'b0, state_ff};
        `REG_COMP: avs_readdata_out <= {26'h0, nonlinear_response_loop_out, comp_ff};
        `REG_TARGET: avs_readdata_out <= {20'h0, target_ff};
        `REG_DUTY: avs_readdata_out <= {20'h0, duty_ff};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end
  assign duty_out = duty_ff;
endmodule

// *** bench/buck_seq_sva.sv ***
// pin-level assertions for the fault and pre-bias sequencer
`timescale 1ns/1ps
`include "buck_seq_map.svh"
module buck_seq_sva (
  // clock, reset and bus writes
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  // sensed levels and straps
  input wire logic [11:0] output_sense_input_in,
  input wire logic [4:0] compensation_strap_pin_in,
  input wire logic light_load_in,
  // driver pins
  input wire logic high_side_pwm_out,
  input wire logic high_side_pwm_oe_out,
  input wire logic low_side_gate_out,
  input wire logic driver_control_out,
  input wire logic power_good_out,
  input wire logic nonlinear_response_loop_out
);
  logic [11:0] target_ff;
  logic emu_ff;
  logic wr_ok;
  logic [15:0] ov_lim;
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  assign ov_lim = 16'(target_ff) + 16'(target_ff) * 16'(`OV_PCT) / 16'(`OV_DIV);
  // shadows follow completed bus writes only
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      target_ff <= `TARGET_RESET;
      emu_ff <= 1'b0;
    end else if (wr_ok && avs_address_in == `REG_TARGET) begin
      target_ff <= avs_writedata_in[11:0];
    end else if (wr_ok && avs_address_in == 5'(`REG_CTRL)) begin
      emu_ff <= avs_writedata_in[`CTRL_DIODE_EMU] && avs_writedata_in[`CTRL_SINGLE_PHASE];
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_gates_no_overlap: assert property (!(high_side_pwm_out && high_side_pwm_oe_out && low_side_gate_out))
    else $error("high and low gate on together");
  a_dead_gap: assert property ($fell(low_side_gate_out) |-> !(high_side_pwm_out && high_side_pwm_oe_out))
    else $error("no gap after low gate off");
  a_idle_gates_off: assert property (!driver_control_out |-> !high_side_pwm_out && !low_side_gate_out)
    else $error("gate on while driver control low");
  a_tri_on_enable: assert property ($rose(driver_control_out) |-> !high_side_pwm_oe_out && !low_side_gate_out)
    else $error("high side not tri-state at driver enable");
  a_drv_off_low: assert property ($fell(driver_control_out) |-> high_side_pwm_oe_out && !high_side_pwm_out)
    else $error("high side not driven low as driver control falls");
  a_pg_ov_drop: assert property ((output_sense_input_in > ov_lim) |-> !power_good_out)
    else $error("power good held during overvoltage");
  a_nlr_strap: assert property (1'b1 |=> nonlinear_response_loop_out == (compensation_strap_pin_in >= 5'd9))
    else $error("nonlinear loop not per strap");
  a_emu_low_off: assert property (light_load_in && emu_ff |=> !low_side_gate_out)
    else $error("low gate on at light load in diode emulation");
endmodule
bind buck_fault_and_prebias_sequencer buck_seq_sva u_sva (
  .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out), .output_sense_input_in(output_sense_input_in),
  .compensation_strap_pin_in(compensation_strap_pin_in), .light_load_in(light_load_in),
  .high_side_pwm_out(high_side_pwm_out), .high_side_pwm_oe_out(high_side_pwm_oe_out),
  .low_side_gate_out(low_side_gate_out), .driver_control_out(driver_control_out),
  .power_good_out(power_good_out), .nonlinear_response_loop_out(nonlinear_response_loop_out)
);

// *** bench/power_stage_model.sv ***
// behavioural power stage giving the sensed output level
`timescale 1ns/1ps
module power_stage_model (
  // controls from the sequencer
  input wire logic clock_in,
  input wire logic driver_control_in,
  input wire logic high_side_pwm_oe_in,
  input wire logic [11:0] duty_in,
  // conditions set by the bench
  input wire logic [11:0] vin_in,
  input wire logic [11:0] prebias_in,
  input wire logic overvolt_in,
  // sensed output
  output logic [11:0] sense_out
);
  logic [11:0] level_ff;
  // level falls back to the pre-bias whenever driver control is low or the high side is tri-stated
  always_ff @(posedge clock_in) begin
    if (driver_control_in && high_side_pwm_oe_in) begin
      level_ff <= 12'((24'(duty_in) * 24'(vin_in)) >> 12);
    end else begin
      level_ff <= prebias_in;
    end
  end
  assign sense_out = overvolt_in ? 12'hFFF : level_ff;
endmodule

// *** bench/buck_fault_and_prebias_sequencer_tb_top.sv ***
// directed bench for the fault and pre-bias sequencer
`timescale 1ns/1ps
`include "buck_seq_map.svh"
module buck_fault_and_prebias_sequencer_tb_top;
  import buck_seq_pkg::*;
  logic clock_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out, light_load_in;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [11:0] input_voltage_in, sense, duty_out;
  logic hs_pwm, hs_oe, low_gate, drv_ctl, pg, overvolt;
  int checks, num_errors;
  logic [11:0] uv_in[3] = '{12'h064, 12'h7D0, 12'h3E8};
  logic [11:0] uv_exp[3] = '{`INPUT_UNDERVOLTAGE_LOCKOUT_MIN, `INPUT_UNDERVOLTAGE_LOCKOUT_MAX, 12'h3E8};
  buck_fault_and_prebias_sequencer u_dut (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .input_voltage_in(input_voltage_in),
    .output_sense_input_in(sense), .input_undervoltage_lockout_strap_in(3'd3), .compensation_strap_pin_in(5'd12),
    .light_load_in(light_load_in), .loop_duty_in(12'd700), .high_side_pwm_out(hs_pwm),
    .high_side_pwm_oe_out(hs_oe), .low_side_gate_out(low_gate),
    .driver_control_out(drv_ctl), .power_good_out(pg), .nonlinear_response_loop_out(),
    .comp_preset_out(), .duty_out(duty_out)
  );
  power_stage_model u_stage (
    .clock_in(clock_in), .driver_control_in(drv_ctl), .high_side_pwm_oe_in(hs_oe),
    .duty_in(duty_out), .vin_in(input_voltage_in), .prebias_in(12'd200),
    .overvolt_in(overvolt), .sense_out(sense)
  );
  always #20 clock_in = ~clock_in;
  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // waitrequest and read data are taken at the rising edge that completes
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    logic wt;
    n = 0;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clock_in);
      wt = avs_waitrequest_out;
      rd = avs_readdata_out;
      n++;
    end while (wt !== 1'b0 && n < 50);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (wt !== 1'b0) begin
      check("bus answer", 32'(wt), 32'h0);
      end_of_test();
    end
  endtask
  task automatic wait_state(input logic [2:0] st);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `REG_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== st && n < 600);
    check("state", 32'(rd[2:0]), 32'(st));
    if (rd[2:0] !== st) end_of_test();
  endtask
  task automatic wait_pin(ref logic s, input logic v, input string what);
    int n;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (s !== v && n < 3000);
    check(what, 32'(s), 32'(v));
    if (s !== v) end_of_test();
  endtask
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    {avs_read_in, avs_write_in, light_load_in, overvolt} = 4'h0;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    input_voltage_in = 12'd1200;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    xfer(1'b0, 5'(`REG_CTRL), 32'h0);
    check("ctrl reset", rd, `CTRL_RESET);
    xfer(1'b0, 5'(`REG_INPUT_UNDERVOLTAGE_LOCKOUT), 32'h0);
    check("strap input_undervoltage_lockout", rd, 32'd720);
    xfer(1'b0, 5'(`REG_FAULT_CFG), 32'h0);
    check("uv default", 32'(rd[1:0]), 32'(UV_SHUTDOWN));
    check("ov default", 32'(rd[2]), 32'(OV_SHUTDOWN));
    xfer(1'b0, 5'h02, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 5'(`REG_INPUT_UNDERVOLTAGE_LOCKOUT), 32'(uv_in[i]));
      xfer(1'b0, 5'(`REG_INPUT_UNDERVOLTAGE_LOCKOUT), 32'h0);
      check("input_undervoltage_lockout clamp", 32'(rd[11:0]), 32'(uv_exp[i]));
    end
    xfer(1'b1, 5'(`REG_INPUT_UNDERVOLTAGE_LOCKOUT), 32'd720);
    xfer(1'b1, `REG_TARGET, 32'd500);
    xfer(1'b1, 5'(`REG_CTRL), 32'h5);
    wait_pin(drv_ctl, 1'b1, "driver control");
    check("tri at enable", 32'(hs_oe), 32'h0);
    wait_pin(hs_oe, 1'b1, "high side driven");
    check("drive after delay", 32'(drv_ctl), 32'h1);
    wait_state(ST_RUN);
    wait_pin(pg, 1'b1, "power good");
    light_load_in <= 1'b1;
    xfer(1'b1, 5'(`REG_CTRL), 32'h7);
    repeat (8) @(negedge clock_in);
    check("emulation low gate", 32'(low_gate), 32'h0);
    xfer(1'b1, 5'(`REG_CTRL), 32'h5);
    light_load_in <= 1'b0;
    overvolt <= 1'b1;
    @(negedge clock_in);
    check("pg on ov", 32'(pg), 32'h0);
    wait_state(ST_FAULT);
    overvolt <= 1'b0;
    wait_state(ST_RUN);
    xfer(1'b1, 5'(`REG_FAULT_CFG), 32'h4);
    overvolt <= 1'b1;
    wait_pin(low_gate, 1'b1, "crowbar low gate");
    overvolt <= 1'b0;
    repeat (20) @(negedge clock_in);
    check("crowbar held", {31'h0, low_gate}, 32'h1);
    check("crowbar high off", {31'h0, hs_pwm}, 32'h0);
    xfer(1'b1, 5'(`REG_CTRL), 32'h15);
    wait_state(ST_RUN);
    xfer(1'b1, 5'(`REG_CTRL), 32'hD);
    overvolt <= 1'b1;
    wait_state(ST_FAULT);
    check("no crowbar ext clock", {31'h0, low_gate}, 32'h0);
    overvolt <= 1'b0;
    wait_state(ST_RUN);
    xfer(1'b1, 5'(`REG_FAULT_CFG), 32'h2);
    input_voltage_in <= 12'd600;
    wait_state(ST_FAULT);
    input_voltage_in <= 12'd1200;
    wait_state(ST_RUN);
    xfer(1'b1, 5'(`REG_FAULT_CFG), 32'h1);
    input_voltage_in <= 12'd600;
    wait_state(ST_OFF);
    input_voltage_in <= 12'd1200;
    repeat (20) @(negedge clock_in);
    wait_state(ST_OFF);
    xfer(1'b1, 5'(`REG_CTRL), 32'h15);
    wait_state(ST_RUN);
    xfer(1'b1, 5'(`REG_FAULT_CFG), 32'h0);
    input_voltage_in <= 12'd600;
    repeat (30) @(negedge clock_in);
    wait_state(ST_RUN);
    input_voltage_in <= 12'd1200;
    xfer(1'b1, 5'(`REG_CTRL), 32'h4);
    wait_pin(hs_oe, 1'b0, "tri on power down");
    check("drive kept", {31'h0, drv_ctl}, 32'h1);
    wait_pin(drv_ctl, 1'b0, "driver released");
    check("high side low", {30'h0, hs_oe, hs_pwm}, 32'h2);
    wait_state(ST_OFF);
    end_of_test();
  end
endmodule
